// >>> include/cxs_params.svh
`ifndef CXS_PARAMS_SVH
`define CXS_PARAMS_SVH

// ----------------------------------------------------------------
// register port offsets
// ----------------------------------------------------------------
`define CXS_OFF_STATUS 8'h00
`define CXS_OFF_VTB 8'h04
`define CXS_OFF_SP 8'h08
`define CXS_OFF_STATE 8'h0c
`define CXS_OFF_SAVED 8'h10

// ----------------------------------------------------------------
// status word layout and reset value
// ----------------------------------------------------------------
`define CXS_SR_T 15
`define CXS_SR_S 13
`define CXS_SR_M 12
`define CXS_SR_I_LSB 8
`define CXS_SR_RESET 16'h2700
`define CXS_SR_WMASK 16'hb71f
`define CXS_VTB_MASK 32'hfff0_0000

// ----------------------------------------------------------------
// vector numbers
// ----------------------------------------------------------------
`define CXS_VEC_ACCESS 8'h02
`define CXS_VEC_ADDRESS 8'h03
`define CXS_VEC_ILLEGAL 8'h04
`define CXS_VEC_PRIV 8'h08
`define CXS_VEC_TRACE 8'h09
`define CXS_VEC_LINE_A 8'h0a
`define CXS_VEC_LINE_F 8'h0b
`define CXS_VEC_DEBUG 8'h0c
`define CXS_VEC_FORMAT 8'h0e
`define CXS_VEC_SPURIOUS 8'h18
`define CXS_VEC_AUTO_BASE 8'h18
`define CXS_VEC_TRAP_BASE 8'h20
`define CXS_VEC_USER_FIRST 8'h40

// ----------------------------------------------------------------
// frame, fault status and acknowledge space
// ----------------------------------------------------------------
`define CXS_FRAME_BYTES 32'h0000_0008
`define CXS_FMT_BASE 2'b01
`define CXS_FS_IFETCH 4'h4
`define CXS_FS_OPWRITE 4'h8
`define CXS_FS_WPROT 4'h9
`define CXS_FS_OPREAD 4'hc
`define CXS_ACK_ADDR 32'hffff_ffe0
`define CXS_LVL_NMI 3'h7

`endif

// >>> include/cxs_pkg.sv
package cxs_pkg;

  // fault and trap causes reported by the execute stage
  typedef enum logic [3:0] {
    CXS_K_ACCESS = 4'h0,
    CXS_K_ADDRESS = 4'h1,
    CXS_K_ILLEGAL = 4'h2,
    CXS_K_PRIV = 4'h3,
    CXS_K_TRACE = 4'h4,
    CXS_K_LINE_A = 4'h5,
    CXS_K_LINE_F = 4'h6,
    CXS_K_DEBUG = 4'h7,
    CXS_K_FORMAT = 4'h8,
    CXS_K_TRAP = 4'h9
  } cxs_kind_t;

  typedef enum logic [6:0] {
    CXS_S_IDLE = 7'b0000001,
    CXS_S_ACK = 7'b0000010,
    CXS_S_PUSH_PC = 7'b0000100,
    CXS_S_PUSH_FV = 7'b0001000,
    CXS_S_VEC = 7'b0010000,
    CXS_S_JUMP = 7'b0100000,
    CXS_S_HALT = 7'b1000000
  } cxs_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic ack_space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cxs_bus_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic autovec;
    logic [31:0] rdata;
  } cxs_bus_rsp_t;

  typedef struct packed {
    logic req;
    cxs_kind_t kind;
    logic [3:0] fs;
    logic [3:0] trap_num;
    logic [31:0] pc_fault;
    logic [31:0] pc_next;
  } cxs_exc_t;

endpackage : cxs_pkg

// >>> design/cxs_sequencer.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "cxs_params.svh"
// Behaviour
// [RULE_01] on any exception, copy status word, set supervisor, clear trace
// [RULE_02] interrupts also clear master bit and load mask with serviced level
// [RULE_03] faults get vector from type; interrupts run an acknowledge cycle
// [RULE_04] acknowledge cycle uses acknowledge space with level in address bits
// [RULE_05] peripheral returns its vector number during the acknowledge cycle
// [RULE_06] frame built on the single shared stack at a word-aligned address
// [RULE_07] frame: format/vector word plus status word, then program counter
// [RULE_08] handler address read at table base plus four times vector
// [RULE_09] table is 256 four-byte vectors, 1024 bytes, 1 Mbyte aligned
// [RULE_10] vectors below 64 architectural, 64 to 255 peripheral interrupts
// [RULE_11] exception processing ends once the first handler fetch starts
// [RULE_12] faulting-instruction PC stacked for vectors 2,3,4,8,10,11,14
// [RULE_13] next-instruction PC stacked for trace, debug, interrupts and traps
// [RULE_14] autovectored levels one to seven use vectors 25 to 31
// [RULE_15] trap n uses vector 32 plus n
// [RULE_16] no interrupt sampling during first handler instruction
// [RULE_17] format is 4 plus old stack bits 1:0; stack drops 8 plus that
// [RULE_18] fault status filled only for access and address errors, else zero
// [RULE_19] fault status codes 0100, 1000, 1001, 1100; others reserved
// [RULE_20] 8-bit vector field from internal fault or peripheral value
// [RULE_21] low twenty bits of table base unimplemented and read zero
// [RULE_22] requests at or below mask ignored, except level 7 edge
module cxs_sequencer
  import cxs_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire cxs_exc_t exc_in, // fault or trap request from core
  input wire logic [2:0] irq_level_pin, // pending interrupt level pins
  input wire logic insn_retire, // core retired an instruction
  output cxs_bus_req_t bus_req, // frame, vector and ack bus request
  input wire cxs_bus_rsp_t bus_rsp, // bus answer
  output logic [31:0] handler_pc, // first handler opcode address
  output logic fetch_start, // pulse: start handler fetch
  output logic halted // fault-on-fault stop
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] cxs_vec_of(input cxs_kind_t k, input logic [3:0] n);
    unique case (k)
      CXS_K_ACCESS: cxs_vec_of = `CXS_VEC_ACCESS;
      CXS_K_ADDRESS: cxs_vec_of = `CXS_VEC_ADDRESS;
      CXS_K_ILLEGAL: cxs_vec_of = `CXS_VEC_ILLEGAL;
      CXS_K_PRIV: cxs_vec_of = `CXS_VEC_PRIV;
      CXS_K_TRACE: cxs_vec_of = `CXS_VEC_TRACE;
      CXS_K_LINE_A: cxs_vec_of = `CXS_VEC_LINE_A;
      CXS_K_LINE_F: cxs_vec_of = `CXS_VEC_LINE_F;
      CXS_K_DEBUG: cxs_vec_of = `CXS_VEC_DEBUG;
      CXS_K_FORMAT: cxs_vec_of = `CXS_VEC_FORMAT;
      CXS_K_TRAP: cxs_vec_of = `CXS_VEC_TRAP_BASE + {4'h0, n}; // RULE_15
      default: cxs_vec_of = `CXS_VEC_ILLEGAL;
    endcase
  endfunction : cxs_vec_of

  // faulting-instruction PC for precise faults, next PC otherwise
  function automatic logic cxs_pc_is_fault(input cxs_kind_t k);
    cxs_pc_is_fault = (k == CXS_K_ACCESS) || (k == CXS_K_ADDRESS) || (k == CXS_K_ILLEGAL) ||
                      (k == CXS_K_PRIV) || (k == CXS_K_LINE_A) || (k == CXS_K_LINE_F) ||
                      (k == CXS_K_FORMAT);
  endfunction : cxs_pc_is_fault

  // only the defined codes get through; reserved codes stack as zero
  function automatic logic [3:0] cxs_fs_of(input cxs_kind_t k, input logic [3:0] fs);
    logic legal;
    legal = (fs == `CXS_FS_IFETCH) || (fs == `CXS_FS_OPWRITE) ||
            (fs == `CXS_FS_WPROT) || (fs == `CXS_FS_OPREAD);
    if ((k == CXS_K_ACCESS || k == CXS_K_ADDRESS) && legal) begin
      cxs_fs_of = fs;
    end else begin
      cxs_fs_of = 4'h0;
    end
  endfunction : cxs_fs_of

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cxs_state_t st;
  cxs_state_t next_st;
  logic [15:0] sr; // processor_status_word
  logic [15:0] sr_saved;
  logic [31:0] vector_table_base;
  logic [31:0] shared_stack_pointer;
  logic [7:0] cur_vec;
  logic [2:0] cur_lvl;
  logic [31:0] cur_pc;
  logic [3:0] cur_fs;
  logic [1:0] orig_lo;
  logic inhibit;
  logic [2:0] irq_s1, irq_s2, irq_s3;
  logic nmi_pend;
  logic take_exc, take_irq, irq_above, nmi_edge;

  // ----------------------------------------------------------------
  // interrupt pin synchroniser and level 7 edge
  // ----------------------------------------------------------------
  // pins come from the system clock domain of the peripherals
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_s1 <= 3'h0;
      irq_s2 <= 3'h0;
      irq_s3 <= 3'h0;
    end else begin
      irq_s1 <= irq_level_pin;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
    end
  end

  assign nmi_edge = (irq_s2 == `CXS_LVL_NMI) && (irq_s3 != `CXS_LVL_NMI);
  assign irq_above = irq_s2 > sr[`CXS_SR_I_LSB +: 3]; // RULE_22
  // a fault beats a pending interrupt; the interrupt stays pending
  assign take_exc = exc_in.req && (st == CXS_S_IDLE);
  assign take_irq = (st == CXS_S_IDLE) && !exc_in.req && !inhibit && (irq_above || nmi_pend); // RULE_16 RULE_22

  // level 7 is edge-latched so it cannot be masked; a new edge beats the take
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1; // RULE_22
    end else if (take_irq) begin
      nmi_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    unique case (st)
      CXS_S_IDLE: begin
        if (take_exc) begin
          next_st = CXS_S_PUSH_PC;
        end else if (take_irq) begin
          next_st = CXS_S_ACK; // RULE_03
        end
      end
      CXS_S_ACK: begin
        if (bus_rsp.done) begin
          next_st = CXS_S_PUSH_PC;
        end
      end
      CXS_S_PUSH_PC: begin
        if (bus_rsp.done) begin
          next_st = bus_rsp.err ? CXS_S_HALT : CXS_S_PUSH_FV;
        end
      end
      CXS_S_PUSH_FV: begin
        if (bus_rsp.done) begin
          next_st = bus_rsp.err ? CXS_S_HALT : CXS_S_VEC;
        end
      end
      CXS_S_VEC: begin
        if (bus_rsp.done) begin
          next_st = bus_rsp.err ? CXS_S_HALT : CXS_S_JUMP;
        end
      end
      CXS_S_JUMP: next_st = CXS_S_IDLE; // RULE_11
      CXS_S_HALT: next_st = CXS_S_HALT;
      default: next_st = CXS_S_HALT;
    endcase
    // a second fault while one is in flight stops the core until reset
    if (exc_in.req && st != CXS_S_IDLE) begin
      next_st = CXS_S_HALT;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= CXS_S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // exception context capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_vec <= 8'h00;
      cur_lvl <= 3'h0;
      cur_pc <= 32'h0000_0000;
      cur_fs <= 4'h0;
      sr_saved <= 16'h0000;
    end else if (take_exc) begin
      cur_vec <= cxs_vec_of(exc_in.kind, exc_in.trap_num); // RULE_03 RULE_20
      cur_pc <= cxs_pc_is_fault(exc_in.kind) ? exc_in.pc_fault : exc_in.pc_next; // RULE_12 RULE_13
      cur_fs <= cxs_fs_of(exc_in.kind, exc_in.fs); // RULE_18 RULE_19
      sr_saved <= sr; // RULE_01
    end else if (take_irq) begin
      cur_lvl <= nmi_pend ? `CXS_LVL_NMI : irq_s2;
      cur_pc <= exc_in.pc_next; // RULE_13
      cur_fs <= 4'h0; // RULE_18
      sr_saved <= sr; // RULE_01
    end else if (st == CXS_S_ACK && bus_rsp.done) begin
      if (bus_rsp.err) begin
        cur_vec <= `CXS_VEC_SPURIOUS; // nobody answered
      end else if (bus_rsp.autovec) begin
        cur_vec <= `CXS_VEC_AUTO_BASE + {5'h00, cur_lvl}; // RULE_14
      end else begin
        cur_vec <= bus_rsp.rdata[7:0]; // RULE_05 RULE_10 RULE_20
      end
    end
  end

  // ----------------------------------------------------------------
  // status word: hardware entry update wins over a software write
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr <= `CXS_SR_RESET;
    end else if (take_exc || take_irq) begin
      sr[`CXS_SR_S] <= 1'b1; // RULE_01
      sr[`CXS_SR_T] <= 1'b0; // RULE_01
      if (take_irq) begin
        sr[`CXS_SR_M] <= 1'b0; // RULE_02
        sr[`CXS_SR_I_LSB +: 3] <= nmi_pend ? `CXS_LVL_NMI : irq_s2; // RULE_02
      end
    end else if (reg_wr && reg_addr == `CXS_OFF_STATUS) begin
      sr <= reg_wdata[15:0] & `CXS_SR_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // stack pointer and table base
  // ----------------------------------------------------------------
  // drop by 8 plus the old low bits, so the frame lands word aligned
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_stack_pointer <= 32'h0000_0000;
      orig_lo <= 2'b00;
    end else if (take_exc || take_irq) begin
      orig_lo <= shared_stack_pointer[1:0];
      shared_stack_pointer <= shared_stack_pointer - `CXS_FRAME_BYTES -
                              {30'h0, shared_stack_pointer[1:0]}; // RULE_06 RULE_17
    end else if (reg_wr && reg_addr == `CXS_OFF_SP) begin
      shared_stack_pointer <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vector_table_base <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `CXS_OFF_VTB) begin
      vector_table_base <= reg_wdata & `CXS_VTB_MASK; // RULE_09 RULE_21
    end
  end

  // ----------------------------------------------------------------
  // bus master: one request per bus state, held until done
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_req <= '0;
    end else if (bus_req.valid) begin
      if (bus_rsp.done) begin
        bus_req.valid <= 1'b0;
      end
    end else begin
      unique case (st)
        CXS_S_ACK: begin
          bus_req <= '{valid: 1'b1, write: 1'b0, ack_space: 1'b1,
                       addr: `CXS_ACK_ADDR | {27'h0, cur_lvl, 2'b00}, wdata: 32'h0}; // RULE_04
        end
        CXS_S_PUSH_PC: begin
          bus_req <= '{valid: 1'b1, write: 1'b1, ack_space: 1'b0,
                       addr: shared_stack_pointer + 32'h4, wdata: cur_pc}; // RULE_07
        end
        CXS_S_PUSH_FV: begin
          bus_req <= '{valid: 1'b1, write: 1'b1, ack_space: 1'b0, addr: shared_stack_pointer,
                       wdata: {`CXS_FMT_BASE, orig_lo, cur_fs[3:2], cur_vec, cur_fs[1:0], sr_saved}};
          // RULE_07 RULE_17 RULE_18 RULE_20
        end
        CXS_S_VEC: begin
          bus_req <= '{valid: 1'b1, write: 1'b0, ack_space: 1'b0,
                       addr: vector_table_base | {22'h0, cur_vec, 2'b00}, wdata: 32'h0}; // RULE_08
        end
        default: bus_req <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // handler launch and first-instruction interrupt shadow
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      handler_pc <= 32'h0000_0000;
    end else if (st == CXS_S_VEC && bus_rsp.done && !bus_rsp.err) begin
      handler_pc <= bus_rsp.rdata; // RULE_08
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_start <= 1'b0;
      halted <= 1'b0;
    end else begin
      fetch_start <= (st == CXS_S_JUMP); // RULE_11
      halted <= (next_st == CXS_S_HALT);
    end
  end

  // shadow lasts until the handler's first instruction retires
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      inhibit <= 1'b0;
    end else if (st == CXS_S_JUMP) begin
      inhibit <= 1'b1; // RULE_16
    end else if (insn_retire) begin
      inhibit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CXS_OFF_STATUS: reg_rdata <= {16'h0, sr};
        `CXS_OFF_VTB: reg_rdata <= vector_table_base & `CXS_VTB_MASK; // RULE_21
        `CXS_OFF_SP: reg_rdata <= shared_stack_pointer;
        `CXS_OFF_STATE: reg_rdata <= {14'h0, cur_vec >= `CXS_VEC_USER_FIRST, halted, inhibit,
                                      cur_vec, st}; // RULE_10
        `CXS_OFF_SAVED: reg_rdata <= {16'h0, sr_saved};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_entry_super_mode: assert property ((take_exc || take_irq) |=> sr[`CXS_SR_S] && !sr[`CXS_SR_T]) // RULE_01
    else $error("status word not supervisor/no-trace after entry");
  a_irq_mask_load: assert property (take_irq |=> !sr[`CXS_SR_M] && sr[`CXS_SR_I_LSB +: 3] == cur_lvl) // RULE_02
    else $error("interrupt entry did not load mask or clear master");
  a_fault_vec_calc: assert property (take_exc |=> cur_vec == cxs_vec_of($past(exc_in.kind), $past(exc_in.trap_num))) // RULE_03
    else $error("fault vector not derived from type");
  a_ack_cycle_addr: assert property (bus_req.valid && bus_req.ack_space |->
      !bus_req.write && bus_req.addr[4:2] == cur_lvl && st == CXS_S_ACK) // RULE_04
    else $error("acknowledge cycle malformed");
  a_frame_word_aligned: assert property (bus_req.valid && bus_req.write |-> bus_req.addr[1:0] == 2'b00) // RULE_06
    else $error("frame write not word aligned");
  a_stack_drop: assert property ((take_exc || take_irq) |=>
      shared_stack_pointer == $past(shared_stack_pointer) - 32'h8 - {30'h0, $past(shared_stack_pointer[1:0])}) // RULE_17
    else $error("stack pointer drop wrong");
  a_format_field: assert property (bus_req.valid && st == CXS_S_PUSH_FV |->
      bus_req.wdata[31:28] == {`CXS_FMT_BASE, orig_lo} && bus_req.wdata[15:0] == sr_saved) // RULE_07
    else $error("format/status longword wrong");
  a_fs_zero_other: assert property (take_exc && exc_in.kind != CXS_K_ACCESS && exc_in.kind != CXS_K_ADDRESS
      |=> cur_fs == 4'h0) // RULE_18
    else $error("fault status not zero");
  a_vector_fetch: assert property (bus_req.valid && st == CXS_S_VEC |->
      bus_req.addr == vector_table_base + {22'h0, cur_vec, 2'b00}) // RULE_08
    else $error("vector fetch address wrong");
  a_autovec_number: assert property (st == CXS_S_ACK && bus_rsp.done && bus_rsp.autovec && !bus_rsp.err
      |=> cur_vec == 8'd24 + {5'h0, cur_lvl}) // RULE_14
    else $error("autovector number wrong");
  a_handler_shadow: assert property (fetch_start |-> inhibit && !take_irq) // RULE_16
    else $error("interrupt sampled in handler first instruction");
  a_fetch_ends: assert property (st == CXS_S_JUMP |=> fetch_start && st == CXS_S_IDLE) // RULE_11
    else $error("handler fetch not started");
  a_vtb_low_zero: assert property (reg_rd && reg_addr == `CXS_OFF_VTB |=> reg_rdata[19:0] == 20'h0) // RULE_21
    else $error("table base low bits not zero");
  a_mask_ignore: assert property (st == CXS_S_IDLE && !inhibit && !exc_in.req && !nmi_pend &&
      irq_s2 <= sr[`CXS_SR_I_LSB +: 3] |-> !take_irq) // RULE_22
    else $error("masked interrupt taken");

  c_irq_full: cover property (take_irq ##[1:60] fetch_start);
  c_trap_full: cover property (take_exc && exc_in.kind == CXS_K_TRAP ##[1:60] fetch_start);
  c_nmi_taken: cover property (nmi_pend && take_irq && sr[`CXS_SR_I_LSB +: 3] == 3'h7);
  c_fault_halt: cover property (st != CXS_S_IDLE && exc_in.req ##1 halted);

endmodule : cxs_sequencer

// >>> sim/cxs_bus_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory and interrupt controller model on the far side of the bus
// ----------------------------------------------------------------
module cxs_bus_partner
  import cxs_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire cxs_bus_req_t bus_req, // request from sequencer
  input wire logic [1:0] wait_cyc, // stall cycles before done
  input wire logic [1:0] ack_mode, // 0 vector, 1 autovector, 2 error
  input wire logic [7:0] ack_vec, // vector handed back on acknowledge
  output cxs_bus_rsp_t bus_rsp // answer to sequencer
);
  logic [1:0] cnt;
  logic [31:0] w_addr [2];
  logic [31:0] w_data [2];
  logic [31:0] r_addr;
  logic [31:0] ack_addr;
  int ack_n;
  // done is one cycle; data lines toggle whenever nothing is being answered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
      bus_rsp <= '0;
      ack_n <= 0;
    end else if (bus_req.valid && !bus_rsp.done && cnt < wait_cyc) begin
      cnt <= cnt + 2'h1;
      bus_rsp.rdata <= ~bus_rsp.rdata;
    end else if (bus_req.valid && !bus_rsp.done) begin
      cnt <= 2'h0;
      bus_rsp.done <= 1'b1;
      bus_rsp.err <= bus_req.ack_space && ack_mode == 2'h2;
      bus_rsp.autovec <= bus_req.ack_space && ack_mode == 2'h1;
      if (bus_req.write) begin
        w_addr <= '{bus_req.addr, w_addr[0]};
        w_data <= '{bus_req.wdata, w_data[0]};
        bus_rsp.rdata <= ~bus_rsp.rdata;
      end else if (bus_req.ack_space) begin
        ack_addr <= bus_req.addr;
        ack_n <= ack_n + 1;
        bus_rsp.rdata <= {24'h0, ack_vec};
      end else begin
        r_addr <= bus_req.addr;
        bus_rsp.rdata <= {bus_req.addr[15:0], ~bus_req.addr[15:1], 1'b0};
      end
    end else begin
      bus_rsp.done <= 1'b0;
      bus_rsp.err <= 1'b0;
      bus_rsp.autovec <= 1'b0;
      bus_rsp.rdata <= ~bus_rsp.rdata;
    end
  end
endmodule : cxs_bus_partner

// >>> sim/core_exception_sequencer_test.sv
`timescale 1ns/1ps
`include "cxs_params.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin errors++; $display("Error %s expected %h seen %h", n, e, a); end end
module core_exception_sequencer_test;
  import cxs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, handler_pc, rd, base;
  cxs_exc_t exc_in = '0;
  logic [2:0] irq_level_pin = 3'h0;
  logic insn_retire = 1'b0;
  cxs_bus_req_t bus_req;
  cxs_bus_rsp_t bus_rsp;
  logic fetch_start, halted;
  logic [1:0] wait_cyc = 2'h0;
  logic [1:0] ack_mode = 2'h0;
  logic [7:0] ack_vec = 8'h40;
  logic [3:0] fsv [5] = '{4'h4, 4'h8, 4'h9, 4'hc, 4'h5};
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  cxs_sequencer DUT (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exc_in,
    .irq_level_pin, .insn_retire, .bus_req, .bus_rsp, .handler_pc, .fetch_start, .halted);
  cxs_bus_partner P (.ref_clk, .rst_b, .bus_req, .bus_rsp, .wait_cyc, .ack_mode, .ack_vec);
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data only stands in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd = reg_rdata;
  endtask : rdr
  // negative k is an interrupt, 0..8 faults, 9..24 trap k-9
  function automatic logic [7:0] vec_of(input int k, input logic [2:0] l);
    logic [7:0] t [10] = '{8'd2, 8'd3, 8'd4, 8'd8, 8'd9, 8'd10, 8'd11, 8'd12, 8'd14, 8'd32};
    if (k >= 0) return t[k > 9 ? 9 : k] + 8'(k > 9 ? k - 9 : 0);
    return ack_mode == 2'h0 ? ack_vec : ack_mode == 2'h1 ? 8'd24 + 8'(l) : 8'd24;
  endfunction : vec_of
  // one exception end to end; nxt is raised during the handler shadow
  task automatic take(input int k, input logic [3:0] fs, input logic [2:0] l, input logic [2:0] nxt);
    logic [31:0] sp, pcf, pcn, nsp, va;
    logic [15:0] sr, sx;
    logic [3:0] fse;
    sp = $urandom;
    sr = 16'($urandom);
    pcf = $urandom;
    pcn = $urandom;
    if (k < 0) sr[10:8] = (l == 3'h7) ? l : l - 3'h1;
    // raise the level while the last shadow holds, so a level 7 edge is latched before the take
    irq_level_pin <= l;
    wr(`CXS_OFF_SP, sp);
    wr(`CXS_OFF_STATUS, {16'h0, sr});
    exc_in <= '{1'b0, cxs_kind_t'(k < 0 ? 0 : k > 9 ? 9 : k), fs, 4'(k - 9), pcf, pcn};
    @(posedge ref_clk);
    insn_retire <= 1'b1;
    exc_in.req <= (k >= 0);
    @(posedge ref_clk);
    insn_retire <= 1'b0;
    exc_in.req <= 1'b0;
    for (n = 0; n < 200 && fetch_start !== 1'b1; n++) @(negedge ref_clk);
    `CHK("fetch_start", 1'b1, fetch_start);
    fse = (k inside {0, 1} && fs inside {4'h4, 4'h8, 4'h9, 4'hc}) ? fs : 4'h0;
    nsp = sp - 32'd8 - 32'(sp[1:0]);
    va = base + {22'h0, vec_of(k, l), 2'b00};
    sr = sr & 16'hb71f;
    sx = (sr | 16'h2000) & 16'h7fff;
    if (k < 0) sx = {sx[15:13], 1'b0, sx[11], l, sx[7:0]};
    `CHK("handler", {va[15:0], ~va[15:1], 1'b0}, handler_pc);
    `CHK("vec_addr", va, P.r_addr);
    `CHK("pc_addr", nsp + 32'd4, P.w_addr[1]);
    `CHK("pc", (k < 0 || k inside {4, 7} || k >= 9) ? pcn : pcf, P.w_data[1]);
    `CHK("fv_addr", nsp, P.w_addr[0]);
    `CHK("fv", {2'b01, sp[1:0], fse[3:2], vec_of(k, l), fse[1:0], sr}, P.w_data[0]);
    if (k < 0) `CHK("ack_addr", 32'hffff_ffe0 | {27'h0, l, 2'b00}, P.ack_addr);
    @(posedge ref_clk);
    irq_level_pin <= nxt;
    n = P.ack_n;
    repeat (12) @(negedge ref_clk);
    `CHK("shadow", n, P.ack_n);
    rdr(`CXS_OFF_SP);
    `CHK("new_sp", nsp, rd);
    rdr(`CXS_OFF_STATUS);
    `CHK("status", {16'h0, sx}, rd);
  endtask : take
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h17c4));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    wr(`CXS_OFF_VTB, 32'hffff_ffff);
    rdr(`CXS_OFF_VTB);
    `CHK("table_base", 32'hfff0_0000, rd);
    rdr(8'h3c);
    `CHK("unmapped", 32'h0, rd);
    base = $urandom;
    wr(`CXS_OFF_VTB, base);
    base &= 32'hfff0_0000;
    // access and address errors alternating over the four fault codes, then one reserved code as an access error
    for (int j = 0; j < 5; j++) take(j % 2, fsv[j], 3'h0, 3'h0);
    for (int k = 2; k < 25; k++) begin
      wait_cyc <= 2'($urandom);
      take(k, 4'($urandom), 3'h0, 3'h0);
    end
    ack_vec <= 8'($urandom_range(64, 255));
    take(-1, 4'h0, 3'h3, 3'h6);
    ack_vec <= 8'd64;
    take(-1, 4'h0, 3'h6, 3'h0);
    ack_mode <= 2'h1;
    for (int l = 1; l < 8; l++) take(-1, 4'h0, 3'(l), 3'h0);
    ack_mode <= 2'h2;
    take(-1, 4'h0, 3'h2, 3'h0);
    // level at the mask must be ignored once the shadow has ended
    wr(`CXS_OFF_STATUS, 32'h2500);
    irq_level_pin <= 3'h5;
    insn_retire <= 1'b1;
    n = P.ack_n;
    @(posedge ref_clk);
    insn_retire <= 1'b0;
    repeat (20) @(negedge ref_clk);
    `CHK("masked", n, P.ack_n);
    `CHK("halted", 1'b0, halted);
    // a second request while the first is in flight must stop the sequencer
    @(posedge ref_clk);
    exc_in.req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    exc_in.req <= 1'b0;
    @(negedge ref_clk);
    `CHK("fault_halt", 1'b1, halted);
    give_verdict();
  end
endmodule : core_exception_sequencer_test
